// File: rtl/bbx_pkg.sv
// Package for the byte/bit instruction execute block.
// Assumes a single 40 MHz clock and an APB master for the control registers.
// How it works
// - Every instruction is one 12-bit word: opcode field then operand fields.
// - The 5-bit file field picks one of 32 file registers as the operand.
// - One instruction cycle is exactly four oscillator periods.
// - An instruction takes one cycle, or two if a test is true or it changes the program counter.
// - Byte instructions write the accumulator when d is 0 and the file register when d is 1.
// - Don't-care encoding bits never change what is executed.
// - 0001 11df ffff adds accumulator and file, routes by d, updates carry, half carry and zero.
// - 1110 kkkk kkkk ANDs the accumulator with the literal into the accumulator, zero flag only.
// - 0001 01df ffff ANDs accumulator with file, routes by d, zero flag only.
// - 0100 bbbf ffff clears bit b of the file register and leaves every flag alone.
package bbx_pkg;

    localparam int unsigned INSN_W     = 12;
    localparam int unsigned FILE_AW    = 5;
    localparam int unsigned NUM_FILES  = 32;
    localparam int unsigned PHASES     = 4;

    // APB register byte offsets
    localparam logic [7:0] REG_INSN    = 8'h00;
    localparam logic [7:0] REG_ACC     = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_FADDR   = 8'h0C;
    localparam logic [7:0] REG_FDATA   = 8'h10;
    localparam logic [7:0] REG_CYCLES  = 8'h14;

    // Status bit positions
    localparam int unsigned ST_CARRY   = 0;
    localparam int unsigned ST_HALF    = 1;
    localparam int unsigned ST_ZERO    = 2;
    localparam int unsigned ST_BUSY    = 3;
    localparam int unsigned ST_ILLEGAL = 4;

    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic [2:0]  FLAGS_RESET  = 3'h0;
    localparam logic [1:0]  PHASE_LAST   = 2'h3;

    typedef enum logic [2:0] {
        BBX_OP_NONE      = 3'b000,
        BBX_OP_ADD_FILE  = 3'b001,
        BBX_OP_AND_LIT   = 3'b010,
        BBX_OP_AND_FILE  = 3'b011,
        BBX_OP_CLR_BIT   = 3'b100
    } bbx_op_t;

    typedef struct packed {
        bbx_op_t             op;
        logic                to_file;
        logic [FILE_AW-1:0]  faddr;
        logic [2:0]          bitsel;
        logic [7:0]          literal;
    } bbx_dec_t;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       zero;
    } bbx_alu_t;

endpackage

// File: rtl/bbx_alu.sv
// Combinational decode and ALU for the byte/bit instruction subset.
// Assumes operands are stable for the whole execute phase.
`timescale 1ns/1ps
`default_nettype none
module bbx_alu
    import bbx_pkg::*;
(
    input  wire logic [INSN_W-1:0] insn,
    input  wire logic [7:0]        acc,
    input  wire logic [7:0]        fval,
    output bbx_dec_t               dec,
    output bbx_alu_t               res
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        // Fields only; bits outside each pattern are never looked at
        dec.faddr   = insn[FILE_AW-1:0];
        dec.to_file = insn[5];
        dec.bitsel  = insn[7:5];
        dec.literal = insn[7:0];
        if (insn[11:6] == 6'h07) begin
            dec.op = BBX_OP_ADD_FILE;
        end else if (insn[11:8] == 4'hE) begin
            dec.op = BBX_OP_AND_LIT;
            dec.to_file = 1'b0;
        end else if (insn[11:6] == 6'h05) begin
            dec.op = BBX_OP_AND_FILE;
        end else if (insn[11:8] == 4'h4) begin
            dec.op = BBX_OP_CLR_BIT;
            dec.to_file = 1'b1;
        end else begin
            dec.op = BBX_OP_NONE;
        end
    end

    always_comb begin
        sum     = {1'b0, acc} + {1'b0, fval};
        low_sum = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};
        res.carry = sum[8];
        res.half  = low_sum[4];
        case (dec.op)
            BBX_OP_ADD_FILE: res.result = sum[7:0];
            BBX_OP_AND_LIT:  res.result = acc & dec.literal;
            BBX_OP_AND_FILE: res.result = acc & fval;
            BBX_OP_CLR_BIT:  res.result = fval & ~(8'h01 << dec.bitsel);
            default:         res.result = acc;
        endcase
        res.zero = (res.result == 8'h00);
    end
endmodule
`default_nettype wire

// File: rtl/bbx_core.sv
// Top of the byte/bit instruction execute block with APB register access.
// Assumes an APB master on sys_clk; the file registers live inside this block.
`timescale 1ns/1ps
`default_nettype none
module bbx_core
    import bbx_pkg::*;
#(
    parameter int unsigned NFILES = NUM_FILES
)(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             insn_done
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]          files_q [NFILES];
    logic [7:0]          acc_q, acc_d;
    logic [2:0]          flags_q, flags_d;     // zero, half, carry
    logic [INSN_W-1:0]   insn_q, insn_d;
    logic [1:0]          phase_q, phase_d;
    logic                busy_q, busy_d;
    logic                illegal_q, illegal_d;
    logic [FILE_AW-1:0]  faddr_q, faddr_d;
    logic [15:0]         cycles_q, cycles_d;
    logic [31:0]         prdata_q, prdata_d;
    logic                done_q, done_d;
    logic                file_we;
    logic [FILE_AW-1:0]  file_wa;
    logic [7:0]          file_wd;
    bbx_dec_t            dec;
    bbx_alu_t            res;

    logic setup_wr, access;
    assign access   = psel & penable;
    assign setup_wr = access & pwrite;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign prdata   = prdata_q;
    assign insn_done = done_q;

    bbx_alu u_alu (
        .insn (insn_q),
        .acc  (acc_q),
        // Index straight from the word so the decode output never loops back into the ALU
        .fval (files_q[insn_q[FILE_AW-1:0]]),
        .dec  (dec),
        .res  (res)
    );

    ////////////////////////////////////////////////////////////////////////
    // Execute sequencing: one instruction cycle is four clock phases.
    // The ALU result is committed on the last phase so operands stay stable.
    always_comb begin
        acc_d     = acc_q;
        flags_d   = flags_q;
        insn_d    = insn_q;
        phase_d   = phase_q;
        busy_d    = busy_q;
        illegal_d = illegal_q;
        faddr_d   = faddr_q;
        cycles_d  = cycles_q;
        done_d    = 1'b0;
        file_we   = 1'b0;
        file_wa   = faddr_q;
        file_wd   = pwdata[7:0];
        if (busy_q) begin
            phase_d = phase_q + 2'h1;
            if (phase_q == PHASE_LAST) begin
                // None of these ops touch the program counter: one cycle each
                busy_d   = 1'b0;
                done_d   = 1'b1;
                cycles_d = cycles_q + 16'h0001;
                illegal_d = (dec.op == BBX_OP_NONE);
                if (dec.op != BBX_OP_NONE) begin
                    if (dec.to_file) begin
                        file_we = 1'b1;
                        file_wa = dec.faddr;
                        file_wd = res.result;
                    end else begin
                        acc_d = res.result;
                    end
                end
                case (dec.op)
                    BBX_OP_ADD_FILE: flags_d = {res.zero, res.half, res.carry};
                    BBX_OP_AND_LIT:  flags_d[ST_ZERO] = res.zero;
                    BBX_OP_AND_FILE: flags_d[ST_ZERO] = res.zero;
                    default:         flags_d = flags_q;
                endcase
            end
        end else if (setup_wr) begin
            case (paddr)
                REG_INSN: begin
                    insn_d  = pwdata[INSN_W-1:0];
                    busy_d  = 1'b1;
                    phase_d = 2'h0;
                end
                REG_ACC:    acc_d   = pwdata[7:0];
                REG_STATUS: flags_d = pwdata[2:0];
                REG_FADDR:  faddr_d = pwdata[FILE_AW-1:0];
                REG_FDATA:  file_we = 1'b1;
                default: ;
            endcase
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                REG_INSN:   prdata_d = {20'h00000, insn_q};
                REG_ACC:    prdata_d = {24'h000000, acc_q};
                REG_STATUS: prdata_d = {27'h0000000, illegal_q, busy_q, flags_q};
                REG_FADDR:  prdata_d = {27'h0000000, faddr_q};
                REG_FDATA:  prdata_d = {24'h000000, files_q[faddr_q]};
                REG_CYCLES: prdata_d = {16'h0000, cycles_q};
                default:    prdata_d = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_q     <= ACC_RESET;
            flags_q   <= FLAGS_RESET;
            insn_q    <= 12'h000;
            phase_q   <= 2'h0;
            busy_q    <= 1'b0;
            illegal_q <= 1'b0;
            faddr_q   <= 5'h00;
            cycles_q  <= 16'h0000;
            prdata_q  <= 32'h00000000;
            done_q    <= 1'b0;
        end else begin
            acc_q     <= acc_d;
            flags_q   <= flags_d;
            insn_q    <= insn_d;
            phase_q   <= phase_d;
            busy_q    <= busy_d;
            illegal_q <= illegal_d;
            faddr_q   <= faddr_d;
            cycles_q  <= cycles_d;
            prdata_q  <= prdata_d;
            done_q    <= done_d;
        end
    end

    // File array has no reset, like ordinary data RAM
    always_ff @(posedge sys_clk) begin
        if (file_we) begin
            files_q[file_wa] <= file_wd;
        end
    end
endmodule
`default_nettype wire

// File: bench/bbx_prog.sv
// Program word builder standing in for program memory.
// Assumes the bench picks the fields; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module bbx_prog
    import bbx_pkg::*;
(
    input  wire logic [1:0]         sel,
    input  wire logic               d,
    input  wire logic [FILE_AW-1:0] f,
    input  wire logic [7:0]         k,
    output logic      [INSN_W-1:0]  word
);
    always_comb begin
        case (sel)
            2'h0: word = {6'h07, d, f};
            2'h1: word = {4'hE, k};
            2'h2: word = {6'h05, d, f};
            default: word = {4'h4, k[2:0], f};
        endcase
    end
endmodule
`default_nettype wire

// File: bench/bbx_core_chk.sv
// Port checker for the execute block top.
// Assumes zero-wait APB; bound to every core instance.
`timescale 1ns/1ps
`default_nettype none
module bbx_core_chk
    import bbx_pkg::*;
#(
    parameter int unsigned NFILES = NUM_FILES
)(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        insn_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wr;
    logic rd;
    assign wr = psel && penable && pwrite && pready && paddr == REG_INSN;
    assign rd = psel && penable && !pwrite && pready;
    property p_late; wr |-> ##[4:5] insn_done; endproperty
    a_late: assert property (p_late) else $error("done not on time");
    property p_quiet; wr |=> !insn_done [*3]; endproperty
    a_quiet: assert property (p_quiet) else $error("done too early");
    property p_pulse; insn_done |=> !insn_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_cause; insn_done |-> $past(wr, 4) || $past(wr, 5); endproperty
    a_cause: assert property (p_cause) else $error("done without insn");
    property p_err; psel |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("slave error");
    property p_acc; rd && paddr == REG_ACC |-> prdata[31:8] == 24'h0; endproperty
    a_acc: assert property (p_acc) else $error("acc wide");
    property p_st; rd && paddr == REG_STATUS |-> prdata[31:5] == 27'h0; endproperty
    a_st: assert property (p_st) else $error("status wide");
    property p_fd; rd && paddr == REG_FDATA |-> prdata[31:8] == 24'h0; endproperty
    a_fd: assert property (p_fd) else $error("file wide");
    c_wr: cover property (wr);
    c_done: cover property (insn_done);
    c_gap: cover property (rd && paddr == 8'h18);
endmodule
bind bbx_core bbx_core_chk #(.NFILES(NFILES)) chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .insn_done(insn_done));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench: APB master, random operands, queued read checks.
// Assumes bbx_core with default file count.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bbx_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, a, v, k, r;
    logic [31:0] pwdata = 32'h0, prdata, t, u, exp_q[$];
    logic pready, pslverr, insn_done, d;
    logic [1:0] sel;
    logic [4:0] f;
    logic [2:0] fl;
    logic [8:0] s;
    logic [11:0] word;
    int num_errors = 0, tests_run = 0, seed = 53273, n_insn = 0;
    always #12.5 sys_clk = ~sys_clk;
    bbx_core dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .insn_done(insn_done));
    bbx_prog prog (.sel(sel), .d(d), .f(f), .k(k), .word(word));
    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task tmo;
        num_errors++;
        $display("ERROR %0t wait ran out", $time);
        print_verdict;
    endtask
    task check32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    // Every transfer leaves one idle edge so no signal is driven twice in a step
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) tmo;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    task wait_done;
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (insn_done === 1'b1) break;
        end
        if (n == 20) tmo;
    endtask
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) check32(prdata, exp_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(REG_ACC, 32'h0);
        rd(REG_STATUS, 32'h0);
        rd(8'h18, 32'h0);
        for (int i = 0; i < 16; i++) begin
            t = $random(seed);
            u = $random(seed);
            {k, v, a} = t[23:0];
            {fl, d, f} = u[8:0];
            sel = i[1:0];
            apb(1'b1, REG_FADDR, {27'h0, f});
            apb(1'b1, REG_FDATA, {24'h0, v});
            apb(1'b1, REG_ACC, {24'h0, a});
            apb(1'b1, REG_STATUS, {29'h0, fl});
            apb(1'b1, REG_INSN, {20'h0, word});
            wait_done;
            n_insn++;
            s = {1'b0, a} + {1'b0, v};
            case (sel)
                2'h0: begin
                    r = s[7:0];
                    fl = {r == 8'h00, ({1'b0, a[3:0]} + {1'b0, v[3:0]}) > 5'h0F, s[8]};
                end
                2'h1: begin
                    r = a & k;
                    d = 1'b0;
                    fl[2] = r == 8'h00;
                end
                2'h2: begin
                    r = a & v;
                    fl[2] = r == 8'h00;
                end
                default: begin
                    r = v & ~(8'h01 << k[2:0]);
                    d = 1'b1;
                end
            endcase
            rd(REG_ACC, {24'h0, d ? a : r});
            rd(REG_FDATA, {24'h0, d ? r : v});
            rd(REG_STATUS, {29'h0, fl});
            $display("step %0d op %0d done", i, sel);
        end
        // A word outside the subset: busy while it runs, then flagged with nothing changed
        apb(1'b1, REG_INSN, 32'h0);
        rd(REG_STATUS, {27'h0, 2'b01, fl});
        wait_done;
        n_insn++;
        rd(REG_STATUS, {27'h0, 2'b10, fl});
        rd(REG_ACC, {24'h0, d ? a : r});
        $display("step %0d op illegal done", n_insn);
        rd(REG_CYCLES, n_insn);
        print_verdict;
    end
endmodule
`default_nettype wire
